// *** hw/cel_event_latch.sv ***
// twelve-channel change-of-condition event latch with processor read port
// assumes processor strobes and condition inputs are synchronous to clk

`timescale 1ns/1ps

`include "cel_map.svh"

module cel_event_latch #(
	parameter int NUM_CH = `CEL_NUM_CHANNELS
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// processor read port
	input  wire logic                      proc_rd_stb,
	input  wire logic [7:0]                proc_addr,
	output logic      [7:0]                proc_rd_data,
	output logic                           proc_rd_valid,
	// per-channel condition sources
	input  wire cel_pkg::cel_cond_t [NUM_CH-1:0] cond_in,
	// per-channel enables from the enable register
	input  wire cel_pkg::cel_cond_t [NUM_CH-1:0] event_enable,
	// interrupt requests
	output logic      [NUM_CH-1:0]         chan_irq,
	output logic                           irq_any
);

	////////////////////////////////////////////////////////////////////////
	// address decoding

	// maps a processor address onto a channel and register
	function automatic cel_pkg::cel_decode_t decode_addr(
		input logic [7:0] addr
	);
		cel_pkg::cel_decode_t dec;
		logic [3:0]           hi;
		logic [3:0]           lo;
		logic                 bank_ok;
		dec     = '0;
		hi      = addr[7:4];
		lo      = addr[3:0];
		bank_ok = 1'b0;
		if (hi >= `CEL_BANK_A_FIRST && hi <= `CEL_BANK_A_LAST) begin
			bank_ok     = 1'b1;
			dec.channel = hi - `CEL_BANK_A_FIRST;
		end else if (hi >= `CEL_BANK_B_FIRST && hi <= `CEL_BANK_B_LAST) begin
			bank_ok     = 1'b1;
			dec.channel = hi - `CEL_BANK_B_FIRST + `CEL_BANK_B_BASE_CH;
		end
		if (bank_ok && lo == `CEL_OFS_EVENT_LO) begin
			dec.hit_event = 1'b1;
		end else if (bank_ok && lo == `CEL_OFS_ALARM_LO) begin
			dec.hit_alarm = 1'b1;
		end
		return dec;
	endfunction

	cel_pkg::cel_decode_t rd_dec;
	cel_pkg::cel_rd_req_t rd_req;

	// bundle the read request
	assign rd_req.rd_stb = proc_rd_stb;
	assign rd_req.addr   = proc_addr;
	assign rd_dec        = decode_addr(rd_req.addr);

	////////////////////////////////////////////////////////////////////////
	// per-channel latches

	cel_pkg::cel_cond_t [NUM_CH-1:0] events;
	cel_pkg::cel_cond_t [NUM_CH-1:0] live;
	logic               [NUM_CH-1:0] clr_sel;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_chan
			// clear only the channel whose event register is read
			assign clr_sel[g] = rd_req.rd_stb && rd_dec.hit_event &&
				(rd_dec.channel == 4'(g));

			cel_chan_latch u_latch (
				.clk           (clk),
				.rstn          (rstn),
				.cond          (cond_in[g]),
				.enable        (event_enable[g]),
				.clear_on_read (clr_sel[g]),
				.events        (events[g]),
				.live          (live[g]),
				.irq           (chan_irq[g])
			);
		end
	endgenerate

	// any enabled event on any channel
	assign irq_any = |chan_irq;

	////////////////////////////////////////////////////////////////////////
	// read data path

	logic [7:0] rd_data_d;
	logic [7:0] rd_data_q;
	logic       rd_valid_q;

	// select latched events or live state; reserved bits read zero
	always_comb begin
		rd_data_d = `CEL_UNMAPPED_DATA;
		if (rd_dec.hit_event && rd_dec.channel < 4'(NUM_CH)) begin
			rd_data_d = {4'h0, events[rd_dec.channel]};
		end else if (rd_dec.hit_alarm && rd_dec.channel < 4'(NUM_CH)) begin
			rd_data_d = {4'h0, live[rd_dec.channel]};
		end
	end

	// capture pre-clear value so the read returns what was latched
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_data_q <= `CEL_RST_DATA;
		end else if (rd_req.rd_stb) begin
			rd_data_q <= rd_data_d;
		end
	end

	// one-cycle answer marker
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req.rd_stb;
		end
	end

	assign proc_rd_data  = rd_data_q;
	assign proc_rd_valid = rd_valid_q;

endmodule

// *** pkg/cel_map.svh ***
// constants for the per-channel event latch register block
// assumes inclusion by the event latch package and design files
`ifndef CEL_MAP_SVH
`define CEL_MAP_SVH

// register map: high nibble picks channel, low nibble picks register
`define CEL_OFS_EVENT_LO      4'h2
`define CEL_OFS_ALARM_LO      4'h3
`define CEL_BANK_A_FIRST      4'h0
`define CEL_BANK_A_LAST       4'h5
`define CEL_BANK_B_FIRST      4'h8
`define CEL_BANK_B_LAST       4'hD
`define CEL_BANK_B_BASE_CH    4'h6

// field positions within both registers
`define CEL_BIT_FIFO_LIMIT    3
`define CEL_BIT_LOCK_LOST     2
`define CEL_BIT_SIGNAL_ABSENT 1
`define CEL_BIT_DRIVE_MON     0

// reset and filler values
`define CEL_RST_EVENTS        4'h0
`define CEL_RST_DATA          8'h00
`define CEL_UNMAPPED_DATA     8'h00

// channel count
`define CEL_NUM_CHANNELS      12

`endif

// *** pkg/cel_pkg.sv ***
// types shared by the per-channel event latch block
// assumes cel_map.svh sits on the include path

`include "cel_map.svh"

package cel_pkg;

	// four watched conditions, packed in register bit order
	typedef struct packed {
		logic fifo_limit_alarm;
		logic receive_lock_lost;
		logic signal_absent_defect;
		logic drive_monitor_flag;
	} cel_cond_t;

	// decoded processor address
	typedef struct packed {
		logic       hit_event;
		logic       hit_alarm;
		logic [3:0] channel;
	} cel_decode_t;

	// processor read request
	typedef struct packed {
		logic       rd_stb;
		logic [7:0] addr;
	} cel_rd_req_t;

endpackage

// *** hw/cel_chan_latch.sv ***
// one channel of change-of-condition latching
// assumes condition inputs are synchronous to clk

`timescale 1ns/1ps

`include "cel_map.svh"

module cel_chan_latch (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rstn,
	// live conditions and enables
	input  wire cel_pkg::cel_cond_t cond,
	input  wire cel_pkg::cel_cond_t enable,
	// read side effect
	input  wire logic           clear_on_read,
	// state out
	output cel_pkg::cel_cond_t  events,
	output cel_pkg::cel_cond_t  live,
	output logic                irq
);

	cel_pkg::cel_cond_t prev_q;
	cel_pkg::cel_cond_t events_q;
	cel_pkg::cel_cond_t events_d;
	cel_pkg::cel_cond_t change;
	logic               primed_q;

	// first sample after reset only primes the history
	always_ff @(posedge clk) begin
		if (!rstn) begin
			primed_q <= 1'b0;
		end else begin
			primed_q <= 1'b1;
		end
	end

	// history of live state
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_q <= `CEL_RST_EVENTS;
		end else begin
			prev_q <= cond;
		end
	end

	// either edge counts as a change
	assign change = primed_q ? (cond ^ prev_q) : `CEL_RST_EVENTS;

	// set beats clear so no event is lost
	always_comb begin
		events_d = events_q;
		if (clear_on_read) begin
			events_d = `CEL_RST_EVENTS;
		end
		events_d = events_d | change;
	end

	// sticky event bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			events_q <= `CEL_RST_EVENTS;
		end else begin
			events_q <= events_d;
		end
	end

	assign events = events_q;
	assign live   = prev_q;
	assign irq    = |(events_q & enable);

endmodule

// *** verif/cel_event_latch_monitor.sv ***
// checker on the event latch read port and interrupt outputs
// assumes binding onto cel_event_latch, one clock domain
`timescale 1ns/1ps
module cel_event_latch_mon #(
	parameter int NUM_CH = 12
) (
	input wire logic                            clk,
	input wire logic                            rstn,
	input wire logic                            proc_rd_stb,
	input wire logic [7:0]                      proc_addr,
	input wire logic [7:0]                      proc_rd_data,
	input wire logic                            proc_rd_valid,
	input wire cel_pkg::cel_cond_t [NUM_CH-1:0] cond_in,
	input wire cel_pkg::cel_cond_t [NUM_CH-1:0] event_enable,
	input wire logic [NUM_CH-1:0]               chan_irq,
	input wire logic                            irq_any
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// read of channel 0 events, and a change on it
	sequence s_rd0;
		proc_rd_stb && proc_addr == 8'h02;
	endsequence
	sequence s_chg0;
		$past(rstn) && $changed(cond_in[0]) && event_enable[0] == 4'hF;
	endsequence
	//////////////////////////////////////////////////////////////////////
	a_valid_follows: assert property (proc_rd_valid == $past(proc_rd_stb))
		else $error("read valid not one cycle after strobe");
	a_upper_zero: assert property (proc_rd_valid |-> !proc_rd_data[7:4])
		else $error("reserved bits not zero");
	a_unmapped_zero: assert property (proc_rd_stb && proc_addr[3:1] != 3'h1
		|=> proc_rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_any_or: assert property (irq_any == |chan_irq)
		else $error("irq_any not or of channels");
	a_gate_off: assert property (event_enable[0] == 4'h0 |-> !chan_irq[0])
		else $error("masked event raised interrupt");
	a_change_sets: assert property (s_chg0 |=> chan_irq[0])
		else $error("change did not set event");
	a_read_clears: assert property (s_rd0 ##0 !$changed(cond_in[0])
		|=> !chan_irq[0])
		else $error("read did not clear events");
	a_race_keeps: assert property (s_rd0 ##0 s_chg0 |=> chan_irq[0])
		else $error("event lost in read race");
	a_data_holds: assert property (!proc_rd_valid |-> $stable(proc_rd_data))
		else $error("read data moved without read");
endmodule
bind cel_event_latch cel_event_latch_mon #(.NUM_CH(NUM_CH)) u_mon (
	.clk           (clk),
	.rstn          (rstn),
	.proc_rd_stb   (proc_rd_stb),
	.proc_addr     (proc_addr),
	.proc_rd_data  (proc_rd_data),
	.proc_rd_valid (proc_rd_valid),
	.cond_in       (cond_in),
	.event_enable  (event_enable),
	.chan_irq      (chan_irq),
	.irq_any       (irq_any)
);

// *** verif/channel_event_latch_register_bench.sv ***
// self-checking bench for the twelve-channel event latch
// assumes cel_pkg and the checker are compiled first
`timescale 1ns/1ps
module channel_event_latch_register_bench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        stb = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [47:0] cond = 48'h0000_0000_0000;
	logic [47:0] en = 48'hFFFF_FFFF_FFFF;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [11:0] chan_irq;
	logic        irq_any;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cyc = 0;
	always #12.5 clk = ~clk;
	cel_event_latch #(.NUM_CH(12)) DUT (.clk(clk), .rstn(rstn),
		.proc_rd_stb(stb), .proc_addr(addr), .proc_rd_data(rdata),
		.proc_rd_valid(rvalid), .cond_in(cond), .event_enable(en),
		.chan_irq(chan_irq), .irq_any(irq_any));
	//////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one read, checked in the valid cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		stb = 1'b1;
		addr = a;
		@(negedge clk);
		stb = 1'b0;
		chk({rvalid, rdata}, {1'b1, e});
	endtask
	task automatic tg(input int ch, input int b);
		@(negedge clk);
		cond[ch*4+b] = ~cond[ch*4+b];
	endtask
	function automatic logic [7:0] ad(input int ch, input logic [3:0] lo);
		return {(ch < 6) ? 4'(ch) : 4'(ch + 2), lo};
	endfunction
	// every channel, one bit each (ch % 4): set, live state, clear on read, both edges
	task automatic t_chan();
		logic [7:0] m;
		for (int ch = 0; ch < 12; ch++) begin
			m = 8'h01 << (ch % 4);
			tg(ch, ch % 4);
			@(negedge clk);
			chk(irq_any, 1'b1);
			chk({8'h00, chan_irq[ch]}, 9'h001);
			rd(ad(ch, 4'h2), m);
			rd(ad(ch, 4'h3), m);
			rd(ad(ch, 4'h2), 8'h00);
			tg(ch, ch % 4);
			rd(ad(ch, 4'h2), m);
			rd(ad(ch, 4'h3), 8'h00);
		end
		$display("t_chan done");
	endtask
	// enable gates interrupt only
	task automatic t_gate();
		en = 48'h0000_0000_0000;
		tg(0, 3);
		@(negedge clk);
		chk(chan_irq[0], 1'b0);
		en = 48'hFFFF_FFFF_FFFF;
		#1;
		chk(chan_irq[0], 1'b1);
		rd(8'h02, 8'h08);
		$display("t_gate done");
	endtask
	// change in the read cycle survives the read
	task automatic t_race();
		@(negedge clk);
		stb = 1'b1;
		addr = 8'h02;
		cond[1] = ~cond[1];
		@(negedge clk);
		stb = 1'b0;
		chk({rvalid, rdata}, 9'h100);
		rd(8'h02, 8'h02);
		$display("t_race done");
	endtask
	// unmapped places read zero
	task automatic t_unmapped();
		tg(6, 0);
		rd(8'h62, 8'h00);
		rd(8'hF2, 8'h00);
		rd(8'h85, 8'h00);
		rd(8'h82, 8'h01);
		$display("t_unmapped done");
	endtask
	// reset mid-run clears events; a level held through reset gives none
	task automatic t_reset();
		tg(1, 3);
		@(negedge clk);
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		chk({8'h00, chan_irq[1]}, 9'h000);
		rd(ad(1, 4'h2), 8'h00);
		rd(ad(1, 4'h3), 8'h08);
		rd(ad(1, 4'h2), 8'h00);
		$display("t_reset done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		t_chan();
		t_gate();
		t_race();
		t_unmapped();
		t_reset();
		test_done();
	end
endmodule
